// ---- hdl/flash_status_regs.sv ----
`timescale 1ns/1ps
module flash_status_regs #(
    parameter int SYNC_DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic [3:0] i_dq,
    output logic [3:0] o_dq,
    output logic [3:0] o_dq_oe_b,
    input wire logic i_quad_mode,
    input wire logic i_busy,
    input wire logic i_prog_suspend,
    input wire logic i_prog_resume,
    input wire logic i_erase_suspend,
    input wire logic i_erase_resume,
    input wire logic i_latency_wr,
    input wire logic [flash_status_pkg::SR_W-1:0] i_latency_wr_data,
    input wire logic [flash_status_pkg::SR_W-1:0] i_fourth_status,
    output logic [flash_status_pkg::SR_W-1:0] o_suspend_status,
    output logic [flash_status_pkg::SR_W-1:0] o_latency_config,
    output logic [flash_status_pkg::DUMMY_W-1:0] o_dummy_cycles,
    output logic [1:0] o_drive_strength
);
    import flash_status_pkg::*;

    if (SYNC_DEPTH < 2) begin : g_bad_depth
        $error("SYNC_DEPTH must be at least 2");
    end

    shift_if sh ();

    status_shifter u_shifter (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .sh(sh)
    );

    // Pin synchroniser: only the last stage is read by logic
    logic [5:0] sync_q [SYNC_DEPTH];
    logic [5:0] pins_s;
    logic sclk_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_idle;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < SYNC_DEPTH; i++) begin
                sync_q[i] <= 6'h10;
            end
            sclk_prev_q <= 1'b0;
        end else begin
            sync_q[0] <= {i_sclk, i_cs_b, i_dq};
            for (int i = 1; i < SYNC_DEPTH; i++) begin
                sync_q[i] <= sync_q[i-1];
            end
            sclk_prev_q <= pins_s[5];
        end
    end

    // Edges found on the synchronised clock; data is delayed alike
    assign pins_s = sync_q[SYNC_DEPTH-1];
    assign cs_idle = pins_s[4];
    assign sclk_rise = !cs_idle && pins_s[5] && !sclk_prev_q;
    assign sclk_fall = !cs_idle && !pins_s[5] && sclk_prev_q;

    // Suspend flags and latency configuration
    logic prog_susp_q;
    logic prog_susp_d;
    logic erase_susp_q;
    logic erase_susp_d;
    logic [1:0] dummy_code_q;
    logic [1:0] dummy_code_d;
    logic [1:0] drive_code_q;
    logic [1:0] drive_code_d;
    logic [DUMMY_W-1:0] dummy_cyc_q;
    logic [DUMMY_W-1:0] dummy_cyc_d;
    logic [SR_W-1:0] suspend_w;
    logic [SR_W-1:0] latency_w;

    // Suspend wins over resume so an event in the same cycle is kept
    always_comb begin
        prog_susp_d = i_prog_suspend | (prog_susp_q & ~i_prog_resume);
        erase_susp_d = i_erase_suspend | (erase_susp_q & ~i_erase_resume);
        dummy_code_d = dummy_code_q;
        drive_code_d = drive_code_q;
        if (i_latency_wr) begin
            dummy_code_d = i_latency_wr_data[DUMMY_COUNT_FIELD_LSB +: 2];
            drive_code_d = i_latency_wr_data[DRIVE_STRENGTH_FIELD_LSB +: 2];
        end
        // Quad clocks two per dummy byte, single line eight
        dummy_cyc_d = DUMMY_W'({3'h0, DUMMY_BYTES[dummy_code_q]}) *
            (i_quad_mode ? QUAD_CLKS_PER_BYTE : SINGLE_CLKS_PER_BYTE);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prog_susp_q <= SUSPEND_STATUS_RST[PROG_SUSP_BIT];
            erase_susp_q <= SUSPEND_STATUS_RST[ERASE_SUSP_BIT];
            dummy_code_q <= DUMMY_CODE_RST;
            drive_code_q <= DRIVE_CODE_RST;
            dummy_cyc_q <= '0;
        end else begin
            prog_susp_q <= prog_susp_d;
            erase_susp_q <= erase_susp_d;
            dummy_code_q <= dummy_code_d;
            drive_code_q <= drive_code_d;
            dummy_cyc_q <= dummy_cyc_d;
        end
    end

    // Register images; unused and reserved positions are tied low
    always_comb begin
        suspend_w = SUSPEND_STATUS_RST;
        suspend_w[PROG_SUSP_BIT] = prog_susp_q;
        suspend_w[ERASE_SUSP_BIT] = erase_susp_q;
        suspend_w[SUSPEND_REG_BUSY_BIT] = i_busy;
        latency_w = '0;
        latency_w[DUMMY_COUNT_FIELD_LSB +: 2] = dummy_code_q;
        latency_w[DRIVE_STRENGTH_FIELD_LSB +: 2] = drive_code_q;
    end

    assign o_suspend_status = suspend_w;
    assign o_latency_config = latency_w;
    assign o_dummy_cycles = dummy_cyc_q;
    assign o_drive_strength = drive_code_q;

    // Link state machine: opcode in on rising edges, data out on falling
    link_state_t state_q;
    link_state_t state_d;
    reg_sel_t sel_q;
    reg_sel_t sel_d;
    logic [7:0] op_q;
    logic [7:0] op_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic quad_q;
    logic quad_d;
    logic [2:0] last_idx;
    logic [7:0] op_next;
    logic load;
    logic shift;

    assign last_idx = quad_q ? QUAD_LAST : SINGLE_LAST;

    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        op_d = op_q;
        cnt_d = cnt_q;
        quad_d = quad_q;
        load = 1'b0;
        shift = 1'b0;
        op_next = quad_q ? {op_q[3:0], pins_s[3:0]} : {op_q[6:0], pins_s[0]};
        if (cs_idle) begin
            // Deselect ends any transfer; mode is taken for the next frame
            state_d = ST_OPCODE;
            op_d = 8'h00;
            cnt_d = 3'h0;
            quad_d = i_quad_mode;
        end else begin
            case (state_q)
                ST_OPCODE: begin
                    if (sclk_rise) begin
                        op_d = op_next;
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == last_idx) begin
                            cnt_d = 3'h0;
                            // Busy and suspend state do not block status reads
                            state_d = ST_SEND;
                            case (op_next)
                                OP_READ_SUSPEND_STATUS: sel_d = SEL_SUSPEND;
                                OP_READ_LATENCY_CONFIG: sel_d = SEL_LATENCY;
                                OP_READ_FOURTH_STATUS: sel_d = SEL_FOURTH;
                                default: state_d = ST_IGNORE;
                            endcase
                        end
                    end
                end
                ST_SEND: begin
                    if (sclk_fall) begin
                        // Each new byte is re-sampled so polling sees live state
                        load = (cnt_q == 3'h0);
                        shift = (cnt_q != 3'h0);
                        cnt_d = (cnt_q == last_idx) ? 3'h0 : cnt_q + 3'h1;
                    end
                end
                ST_IGNORE: begin
                    state_d = ST_IGNORE;
                end
                default: begin
                    state_d = ST_OPCODE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_OPCODE;
            sel_q <= SEL_SUSPEND;
            op_q <= 8'h00;
            cnt_q <= 3'h0;
            quad_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            quad_q <= quad_d;
        end
    end

    // Shifter control and byte selection
    always_comb begin
        sh.load = load;
        sh.shift = shift;
        sh.quad = quad_q;
        case (sel_q)
            SEL_SUSPEND: sh.load_byte = suspend_w;
            SEL_LATENCY: sh.load_byte = latency_w;
            SEL_FOURTH: sh.load_byte = i_fourth_status;
            default: sh.load_byte = 8'h00;
        endcase
    end

    // Drive only while sending; single mode uses the data-out lane alone
    assign o_dq = sh.dout;
    assign o_dq_oe_b = (state_q != ST_SEND) ? OE_B_OFF : (quad_q ? OE_B_QUAD : OE_B_SINGLE);

    property p_prog_set;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_prog_suspend |=> prog_susp_q ##1 (prog_susp_q || $past(i_prog_resume));
    endproperty
    a_prog_set: assert property (p_prog_set) else $error("program suspend flag not set");

    property p_prog_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_prog_resume && !i_prog_suspend) |=> !o_suspend_status[PROG_SUSP_BIT];
    endproperty
    a_prog_clear: assert property (p_prog_clear) else $error("program suspend flag not cleared");

    property p_erase_set;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_erase_suspend && i_erase_resume) |=> o_suspend_status[ERASE_SUSP_BIT];
    endproperty
    a_erase_set: assert property (p_erase_set) else $error("erase suspend lost to resume");

    property p_erase_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_erase_resume && !i_erase_suspend) |=> !o_suspend_status[ERASE_SUSP_BIT];
    endproperty
    a_erase_clear: assert property (p_erase_clear) else $error("erase suspend flag not cleared");

    property p_suspend_load;
        @(posedge i_clk) disable iff (!i_rst_b)
        (load && sel_q == SEL_SUSPEND) |-> (sh.load_byte[0] == i_busy && sh.load_byte[7:4] == 4'h0
            && !sh.load_byte[1]);
    endproperty
    a_suspend_load: assert property (p_suspend_load) else $error("suspend byte busy or reserved wrong");

    property p_latency_reserved;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_latency_wr |=> (o_latency_config & ~LATENCY_WRITABLE_MASK) == 8'h00;
    endproperty
    a_latency_reserved: assert property (p_latency_reserved) else $error("latency reserved bits set");

    property p_dummy_quad;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_quad_mode && dummy_code_q == 2'h3) ##1 (i_quad_mode && dummy_code_q == 2'h3)
            |=> o_dummy_cycles == 6'h0A;
    endproperty
    a_dummy_quad: assert property (p_dummy_quad) else $error("quad dummy count not ten");

    property p_read_accept;
        @(posedge i_clk) disable iff (!i_rst_b)
        (state_q == ST_OPCODE && !cs_idle && sclk_rise && cnt_q == last_idx
            && op_next == OP_READ_LATENCY_CONFIG) |=> (state_q == ST_SEND && sel_q == SEL_LATENCY);
    endproperty
    a_read_accept: assert property (p_read_accept) else $error("latency read not accepted");

    property p_repeat;
        @(posedge i_clk) disable iff (!i_rst_b)
        (state_q == ST_SEND && !cs_idle) |=> (state_q == ST_SEND || $past(cs_idle) || cs_idle
            || $past(pins_s[4]));
    endproperty
    a_repeat: assert property (p_repeat) else $error("send left while selected");

    property p_msb_first;
        @(posedge i_clk) disable iff (!i_rst_b)
        (load && !quad_q) |=> (o_dq[1] == $past(sh.load_byte[7]) && o_dq_oe_b == OE_B_SINGLE);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit is not the MSB");

    property p_drive;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_latency_wr |=> o_drive_strength == $past(i_latency_wr_data[3:2]);
    endproperty
    a_drive: assert property (p_drive) else $error("drive strength code not stored");

    property p_reset_zero;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(i_rst_b) |-> (!prog_susp_q && !erase_susp_q);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("suspend flags not zero after reset");
endmodule : flash_status_regs

// ---- common/flash_status_pkg.sv ----
// Notes on behaviour
// - Program-suspended flag sits in suspend bit 3; set on suspend, cleared on resume.
// - Erase-suspended flag sits in suspend bit 2; set on suspend, cleared on resume.
// - All volatile suspend-register bits are zero after power-up or reset; the code lets bit 0 follow i_busy through reset.
// - Suspend-register read returns the primary busy flag in bit 0.
// - Suspend-register bit 1 and bits 7 to 4 always read zero.
// - Latency-config read opcode is accepted at any time, suspend cycle or not.
// - Held chip select after a status read keeps repeating the register byte.
// - Latency bits 5:4 pick dummy bytes: 00=3, 01=2, 10=4, 11=5.
// - In quad mode each dummy byte spans two clocks: 4, 6, 8, 10.
// - Latency bits 3:2 set drive: 01 full, 10 half, 11 third, 00 default.
// - Latency-config bits 7, 6, 1 and 0 are reserved with no function.
// - Fourth-status read is accepted any time, busy or not, and repeats.
// - Third and fourth status reads also work in quad-peripheral mode.
package flash_status_pkg;
    localparam int SR_W = 8;
    localparam int DUMMY_W = 6;
    // Opcodes of the three status reads
    localparam logic [7:0] OP_READ_SUSPEND_STATUS = 8'h09;
    localparam logic [7:0] OP_READ_LATENCY_CONFIG = 8'h95;
    localparam logic [7:0] OP_READ_FOURTH_STATUS = 8'h85;
    // Field positions
    localparam int SUSPEND_REG_BUSY_BIT = 0;
    localparam int ERASE_SUSP_BIT = 2;
    localparam int PROG_SUSP_BIT = 3;
    localparam int DRIVE_STRENGTH_FIELD_LSB = 2;
    localparam int DUMMY_COUNT_FIELD_LSB = 4;
    localparam logic [7:0] LATENCY_WRITABLE_MASK = 8'h3C;
    // Reset values
    localparam logic [7:0] SUSPEND_STATUS_RST = 8'h00;
    localparam logic [1:0] DUMMY_CODE_RST = 2'h0;
    localparam logic [1:0] DRIVE_CODE_RST = 2'h0;
    // Dummy bytes per code, and clocks per dummy byte
    localparam logic [2:0] DUMMY_BYTES [4] = '{3'h3, 3'h2, 3'h4, 3'h5};
    localparam logic [DUMMY_W-1:0] QUAD_CLKS_PER_BYTE = 6'h02;
    localparam logic [DUMMY_W-1:0] SINGLE_CLKS_PER_BYTE = 6'h08;
    // Last transfer index within one byte, and lane output enables
    localparam logic [2:0] SINGLE_LAST = 3'h7;
    localparam logic [2:0] QUAD_LAST = 3'h1;
    localparam logic [3:0] OE_B_SINGLE = 4'hD;
    localparam logic [3:0] OE_B_QUAD = 4'h0;
    localparam logic [3:0] OE_B_OFF = 4'hF;

    typedef enum logic [1:0] {
        ST_OPCODE = 2'b00,
        ST_SEND = 2'b01,
        ST_IGNORE = 2'b10
    } link_state_t;

    typedef enum logic [1:0] {
        SEL_SUSPEND = 2'b00,
        SEL_LATENCY = 2'b01,
        SEL_FOURTH = 2'b10
    } reg_sel_t;
endpackage : flash_status_pkg

// ---- common/shift_if.sv ----
`timescale 1ns/1ps
// Load/shift control between the link logic and the output shifter
interface shift_if;
    logic load;
    logic shift;
    logic quad;
    logic [7:0] load_byte;
    logic [3:0] dout;
    modport ctrl (output load, output shift, output quad, output load_byte, input dout);
    modport shifter (input load, input shift, input quad, input load_byte, output dout);
endinterface : shift_if

// ---- hdl/status_shifter.sv ----
`timescale 1ns/1ps
module status_shifter (
    input wire logic i_clk,
    input wire logic i_rst_b,
    shift_if.shifter sh
);
    logic [7:0] data_q;
    logic [7:0] data_d;

    // Load wins over shift; quad moves a nibble per edge
    always_comb begin
        data_d = data_q;
        if (sh.load) begin
            data_d = sh.load_byte;
        end else if (sh.shift) begin
            data_d = sh.quad ? {data_q[3:0], 4'h0} : {data_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_q <= 8'h00;
        end else begin
            data_q <= data_d;
        end
    end

    // Single mode drives only the data-out lane, MSB first
    assign sh.dout = sh.quad ? data_q[7:4] : {2'b00, data_q[7], 1'b0};
endmodule : status_shifter

// ---- dv/spi_host_model.sv ----
`timescale 1ns/1ps
// Host side of the status link: makes the serial clock and select, sends opcodes, collects the answer
module spi_host_model (
    input wire logic [3:0] i_dq,
    input wire logic [3:0] i_dq_oe_b,
    output logic o_sclk,
    output logic o_cs_b,
    output logic [3:0] o_dq
);
    localparam time HALF = 80;

    // Clock stands low and select high outside frames
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_dq = 4'hA;
    end

    // One serial clock; lanes are read late in the high phase, long after the device has settled them
    task automatic pulse(output logic [3:0] seen, output logic [3:0] oe_seen);
        #HALF o_sclk = 1'b1;
        #(HALF - 5) seen = i_dq;
        oe_seen = i_dq_oe_b;
        #5 o_sclk = 1'b0;
    endtask : pulse

    // One select frame: opcode, then whole bytes read MSB first, a new byte after every eighth bit
    task automatic xfer(input logic [7:0] op, input bit quad, input int nbytes,
                        output logic [15:0] data, output logic [3:0] oe_seen);
        logic [3:0] s;
        int i;
        #7 o_cs_b = 1'b0;
        data = '0;
        for (i = 0; i < (quad ? 2 : 8); i++) begin
            if (quad) begin
                o_dq = op[7 - 4 * i -: 4];
            end else begin
                o_dq[0] = op[7 - i];
            end
            pulse(s, oe_seen);
        end
        // Released lanes toggle every clock so a stale level never passes for a driven one
        for (i = 0; i < nbytes * (quad ? 2 : 8); i++) begin
            o_dq = ~o_dq;
            pulse(s, oe_seen);
            data = quad ? {data[11:0], s} : {data[14:0], s[1]};
        end
        #HALF o_cs_b = 1'b1;
        #(4 * HALF);
    endtask : xfer
endmodule : spi_host_model

// ---- dv/flash_status_regs_two_to_four_tb.sv ----
`timescale 1ns/1ps
module flash_status_regs_two_to_four_tb;
    import flash_status_pkg::*;
    logic clk, rst_b, quad_mode, busy, lat_wr;
    logic prog_susp, prog_res, erase_susp, erase_res;
    logic [7:0] lat_data, fourth, susp_st, lat_cfg;
    logic [5:0] dummy_cyc;
    logic [1:0] drive;
    logic sclk, cs_b;
    logic [3:0] host_dq, dut_dq, dq_oe_b, wire_dq;
    int fail_count, n_tests;
    // Bytes per dummy code; a host picks 00 for unaligned and 01 for aligned fast reads
    int nb [4] = '{3, 2, 4, 5};
    logic [3:0] fv [6] = '{4'h8, 4'h2, 4'h4, 4'h1, 4'hC, 4'h3};
    logic [7:0] fx [6] = '{8'h08, 8'h0C, 8'h04, 8'h00, 8'h08, 8'h0C};

    // Each lane carries the device when its enable is low, otherwise the host
    assign wire_dq = (dut_dq & ~dq_oe_b) | (host_dq & dq_oe_b);

    flash_status_regs dut (.i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b), .i_dq(wire_dq),
        .o_dq(dut_dq), .o_dq_oe_b(dq_oe_b), .i_quad_mode(quad_mode), .i_busy(busy),
        .i_prog_suspend(prog_susp), .i_prog_resume(prog_res), .i_erase_suspend(erase_susp),
        .i_erase_resume(erase_res), .i_latency_wr(lat_wr), .i_latency_wr_data(lat_data),
        .i_fourth_status(fourth), .o_suspend_status(susp_st), .o_latency_config(lat_cfg),
        .o_dummy_cycles(dummy_cyc), .o_drive_strength(drive));

    spi_host_model host (.i_dq(wire_dq), .i_dq_oe_b(dq_oe_b), .o_sclk(sclk), .o_cs_b(cs_b), .o_dq(host_dq));

    always #10 clk = ~clk;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Wait edges, then step past them so flop updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Flag pulses in the order prog suspend, prog resume, erase suspend, erase resume
    task automatic flags(input logic [3:0] v);
        @(posedge clk);
        {prog_susp, prog_res, erase_susp, erase_res} <= v;
        @(posedge clk);
        {prog_susp, prog_res, erase_susp, erase_res} <= 4'h0;
        #1;
    endtask : flags

    task automatic rd(input logic [7:0] op, input bit quad, input int n, input logic [15:0] exp,
                      input logic [3:0] oe_exp);
        logic [15:0] d;
        logic [3:0] oe;
        host.xfer(op, quad, n, d, oe);
        if (oe_exp !== 4'hF) begin
            check("read data", exp, d);
        end
        check("lane enable in frame", {12'h000, oe_exp}, {12'h000, oe});
        check("lane enable idle", 16'h000F, {12'h000, dq_oe_b});
    endtask : rd

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // A hung link frame would stall the sequence; the whole run needs well under 200 us
    initial begin
        #200us;
        fail_count++;
        wrap_up();
    end

    initial begin
        int i;
        clk = 1'b0;
        rst_b = 1'b0;
        {quad_mode, busy, lat_wr, prog_susp, prog_res, erase_susp, erase_res} = 7'h00;
        lat_data = 8'h00;
        fourth = 8'hC5;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        cyc(4);
        check("suspend status reset", 16'h0000, {8'h00, susp_st});
        check("latency config reset", 16'h0000, {8'h00, lat_cfg});
        check("dummy cycles reset", 16'd24, {10'h000, dummy_cyc});
        $display("test reset values done");

        for (i = 0; i < 6; i++) begin
            flags(fv[i]);
            check("suspend flags", {8'h00, fx[i]}, {8'h00, susp_st});
        end
        @(posedge clk);
        busy <= 1'b1;
        #1;
        check("busy mirror", 16'h000D, {8'h00, susp_st});
        $display("test suspend flags done");

        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            lat_wr <= 1'b1;
            lat_data <= {2'b11, 2'(i), 2'(3 - i), 2'b11};
            @(posedge clk);
            lat_wr <= 1'b0;
            #1;
            check("latency config", {8'h00, 2'b00, 2'(i), 2'(3 - i), 2'b00}, {8'h00, lat_cfg});
            check("drive strength", 16'(3 - i), {14'h0000, drive});
            cyc(1);
            check("dummy single", 16'(nb[i] * 8), {10'h000, dummy_cyc});
            @(posedge clk);
            quad_mode <= 1'b1;
            cyc(2);
            check("dummy quad", 16'(nb[i] * 2), {10'h000, dummy_cyc});
            @(posedge clk);
            quad_mode <= 1'b0;
            cyc(2);
        end
        $display("test latency register done");

        rd(OP_READ_SUSPEND_STATUS, 1'b0, 2, 16'h0D0D, 4'hD);
        rd(OP_READ_LATENCY_CONFIG, 1'b0, 2, 16'h3030, 4'hD);
        rd(OP_READ_FOURTH_STATUS, 1'b0, 2, 16'hC5C5, 4'hD);
        rd(8'h5A, 1'b0, 1, 16'h0000, 4'hF);
        // Busy is cleared first; the whole byte is compared, reserved positions included, nothing is masked
        @(posedge clk);
        busy <= 1'b0;
        rd(OP_READ_SUSPEND_STATUS, 1'b0, 1, 16'h000C, 4'hD);
        $display("test single lane reads done");

        @(posedge clk);
        quad_mode <= 1'b1;
        cyc(4);
        rd(OP_READ_LATENCY_CONFIG, 1'b1, 2, 16'h3030, 4'h0);
        rd(OP_READ_FOURTH_STATUS, 1'b1, 2, 16'hC5C5, 4'h0);
        $display("test quad reads done");

        @(posedge clk);
        busy <= 1'b1;
        rst_b <= 1'b0;
        cyc(2);
        check("suspend status in reset", 16'h0001, {8'h00, susp_st});
        check("latency config in reset", 16'h0000, {8'h00, lat_cfg});
        check("lane enable in reset", 16'h000F, {12'h000, dq_oe_b});
        @(posedge clk);
        rst_b <= 1'b1;
        cyc(4);
        // Mode is still quad, so the default code gives three bytes of two clocks
        check("suspend status after reset", 16'h0001, {8'h00, susp_st});
        check("dummy cycles after reset", 16'd6, {10'h000, dummy_cyc});
        rd(OP_READ_LATENCY_CONFIG, 1'b1, 1, 16'h0000, 4'h0);
        $display("test second reset done");
        wrap_up();
    end
endmodule : flash_status_regs_two_to_four_tb
